/* hw/ssw_supervisor.sv */
// Supply supervisor with watchdog, manual reset and write inhibit
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor #(
  parameter int unsigned HOLD_CYCLES = ssw_pkg::HOLD_CYCLES,
  parameter int unsigned WDOG_CYCLES = ssw_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Comparator results
  input  wire logic supply_ok_i,
  input  wire logic aux_below_ref_i,
  // Host side
  input  wire logic watchdog_kick_in_i,
  input  wire logic reset_n_pin_i,
  // Reset outputs, reset_lo_o open drain, reset_hi_o drives high, enable low while driving
  output logic      reset_hi_o,
  output logic      reset_hi_oe_n_o,
  output logic      reset_lo_o,
  output logic      reset_lo_oe_n_o,
  // Auxiliary low-voltage output, open drain
  output logic      aux_low_out_o,
  output logic      aux_low_out_oe_n_o,
  // Memory write protection
  output logic      write_inhibit_o
);

  // ************************************************************
  // Input edge capture
  // ************************************************************
  logic kick_ff;
  logic supply_ok_ff;
  logic pin_low_ff;
  logic nxt_kick;
  logic nxt_supply_ok;
  logic nxt_pin_low;
  logic kick_edge;

  always_comb begin
    nxt_kick      = watchdog_kick_in_i;
    nxt_supply_ok = supply_ok_i;
    // Ignore our own drive of the pin: only count a low we are not making
    nxt_pin_low   = !reset_n_pin_i && reset_lo_oe_n_o;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      kick_ff      <= 1'b0;
      supply_ok_ff <= 1'b0;
      pin_low_ff   <= 1'b0;
    end else begin
      kick_ff      <= nxt_kick;
      supply_ok_ff <= nxt_supply_ok;
      pin_low_ff   <= nxt_pin_low;
    end
  end

  // Only read in the run state, so a stale compare just after reset is harmless
  // Kick edge detect
  assign kick_edge = kick_ff ^ watchdog_kick_in_i;

  // ************************************************************
  // Reset sequencer
  // ************************************************************
  ssw_pkg::ssw_state_t state_ff;
  ssw_pkg::ssw_state_t nxt_state;
  logic                hold_load;
  logic                hold_done;
  logic                wdog_load;
  logic                wdog_done;
  logic                cause;

  assign cause = !supply_ok_ff || pin_low_ff;

  always_comb begin
    nxt_state = state_ff;
    hold_load = 1'b0;
    wdog_load = 1'b0;
    case (state_ff)
      ssw_pkg::SSW_ST_ACTIVE: begin
        // Keep the hold timer full so every cause gets the whole hold
        hold_load = 1'b1;
        if (!cause) begin
          nxt_state = ssw_pkg::SSW_ST_HOLD;
        end
      end
      ssw_pkg::SSW_ST_HOLD: begin
        if (cause) begin
          nxt_state = ssw_pkg::SSW_ST_ACTIVE;
        end else if (hold_done) begin
          wdog_load = 1'b1;
          nxt_state = ssw_pkg::SSW_ST_RUN;
        end
      end
      ssw_pkg::SSW_ST_RUN: begin
        wdog_load = kick_edge;
        if (cause || wdog_done) begin
          nxt_state = ssw_pkg::SSW_ST_ACTIVE;
        end
      end
      default: begin
        nxt_state = ssw_pkg::SSW_ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff <= ssw_pkg::SSW_ST_ACTIVE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ssw_timer u_hold (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .load_i    (hold_load),
    .run_i     (state_ff == ssw_pkg::SSW_ST_HOLD),
    .start_i   (ssw_pkg::CNT_W'(HOLD_CYCLES - 1)),
    .expired_o (hold_done)
  );

  ssw_timer u_wdog (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .load_i    (wdog_load),
    .run_i     (state_ff == ssw_pkg::SSW_ST_RUN),
    .start_i   (ssw_pkg::CNT_W'(WDOG_CYCLES - 1)),
    .expired_o (wdog_done)
  );

  // ************************************************************
  // Reset outputs
  // ************************************************************
  logic nxt_reset_hi;
  logic nxt_reset_hi_oe_n;
  logic nxt_reset_lo;
  logic nxt_reset_lo_oe_n;

  always_comb begin
    // Active unless the sequencer is heading for the run state
    nxt_reset_hi      = (nxt_state != ssw_pkg::SSW_ST_RUN);
    nxt_reset_hi_oe_n = !nxt_reset_hi;
    nxt_reset_lo      = 1'b0;
    nxt_reset_lo_oe_n = !nxt_reset_hi;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      reset_hi_o      <= 1'b1;
      reset_hi_oe_n_o <= 1'b0;
      reset_lo_o      <= 1'b0;
      reset_lo_oe_n_o <= 1'b0;
    end else begin
      reset_hi_o      <= nxt_reset_hi;
      reset_hi_oe_n_o <= nxt_reset_hi_oe_n;
      reset_lo_o      <= nxt_reset_lo;
      reset_lo_oe_n_o <= nxt_reset_lo_oe_n;
    end
  end

  // ************************************************************
  // Auxiliary low-voltage output
  // ************************************************************
  logic nxt_aux_low;
  logic nxt_aux_low_oe_n;

  always_comb begin
    nxt_aux_low      = 1'b0;
    nxt_aux_low_oe_n = !aux_below_ref_i;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aux_low_out_o      <= 1'b0;
      aux_low_out_oe_n_o <= 1'b0;
    end else begin
      aux_low_out_o      <= nxt_aux_low;
      aux_low_out_oe_n_o <= nxt_aux_low_oe_n;
    end
  end

  // ************************************************************
  // Memory write protection
  // ************************************************************
  logic nxt_inhibit;

  always_comb begin
    // Follows the raw comparator so writes stop before the sequencer reacts
    nxt_inhibit = !supply_ok_i;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      write_inhibit_o <= 1'b1;
    end else begin
      write_inhibit_o <= nxt_inhibit;
    end
  end

endmodule
`default_nettype wire

/* hw/ssw_pkg.sv */
// Constants shared by the supply supervisor and watchdog reset block
package ssw_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned HOLD_MS         = 200;
  localparam int unsigned WDOG_MS         = 1600;
  localparam int unsigned HOLD_CYCLES     = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned WDOG_CYCLES     = (CLK_HZ / 1000) * WDOG_MS;
  localparam int unsigned CNT_W           = 32;

  // ************************************************************
  // Reset sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    SSW_ST_ACTIVE = 2'b00,
    SSW_ST_HOLD   = 2'b01,
    SSW_ST_RUN    = 2'b10
  } ssw_state_t;

endpackage

/* hw/ssw_timer.sv */
// Down counter that reports expiry, restartable by a load pulse
`timescale 1ns/1ps
`default_nettype none
module ssw_timer (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  // Control
  input  wire logic                       load_i,
  input  wire logic                       run_i,
  input  wire logic [ssw_pkg::CNT_W-1:0]  start_i,
  // Status
  output logic                            expired_o
);

  logic [ssw_pkg::CNT_W-1:0] cnt_ff;
  logic [ssw_pkg::CNT_W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt = start_i;
    end else if (run_i && (cnt_ff != '0)) begin
      nxt_cnt = cnt_ff - ssw_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired_o = (cnt_ff == '0) && !load_i;

endmodule
`default_nettype wire

/* verif/ssw_monitor.sv */
// Concurrent checks on the supervisor reset, auxiliary and write inhibit outputs
`timescale 1ns/1ps
`default_nettype none
module ssw_monitor #(
  parameter int HOLD_CYCLES = 20,
  parameter int WDOG_CYCLES = 50
) (
  // Watched ports
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic supply_ok_i,
  input wire logic aux_below_ref_i,
  input wire logic watchdog_kick_in_i,
  input wire logic reset_n_pin_i,
  input wire logic reset_hi_o,
  input wire logic reset_hi_oe_n_o,
  input wire logic reset_lo_o,
  input wire logic reset_lo_oe_n_o,
  input wire logic aux_low_out_o,
  input wire logic aux_low_out_oe_n_o,
  input wire logic write_inhibit_o
);
  logic [31:0] hold_ff;
  logic [31:0] idle_ff;
  wire         act = !reset_lo_oe_n_o;
  always_ff @(posedge clock_i) begin
    hold_ff <= (rst_n_i && act && supply_ok_i) ? hold_ff + 32'h1 : 32'h0;
    idle_ff <= (!rst_n_i || act || $changed(watchdog_kick_in_i)) ? 32'h0 : idle_ff + 32'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_recover; !supply_ok_i ##1 supply_ok_i; endsequence
  sequence s_ext_low; reset_lo_oe_n_o && !reset_n_pin_i; endsequence
  a_supply_reset: assert property (!supply_ok_i |-> ##2 act)
    else $error("reset not raised on low supply");
  a_pair_polarity: assert property (reset_hi_oe_n_o == reset_lo_oe_n_o
    && reset_hi_o == act && !reset_lo_o) else $error("reset outputs disagree");
  a_recover_hold: assert property (s_recover |=> act [*8])
    else $error("reset dropped right after recovery");
  a_hold_min: assert property ($rose(reset_lo_oe_n_o) |-> hold_ff >= HOLD_CYCLES)
    else $error("reset hold too short");
  a_hold_max: assert property (hold_ff <= HOLD_CYCLES + 6)
    else $error("reset hold too long");
  a_wdog_expiry: assert property (idle_ff <= WDOG_CYCLES + 3)
    else $error("watchdog did not expire");
  a_kick_restart: assert property ($fell(reset_lo_oe_n_o) && $past(supply_ok_i, 2)
    && $past(reset_n_pin_i, 2) |-> idle_ff >= WDOG_CYCLES - 2)
    else $error("watchdog expired despite kicks");
  a_manual_start: assert property (s_ext_low |-> ##2 act)
    else $error("manual reset ignored");
  a_aux_follow: assert property (1 |=> aux_low_out_oe_n_o == !$past(aux_below_ref_i)
    && !aux_low_out_o) else $error("aux output wrong");
  a_write_block: assert property (1 |=> write_inhibit_o == !$past(supply_ok_i))
    else $error("write inhibit wrong");
endmodule
bind ssw_supervisor ssw_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) mon (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .supply_ok_i(supply_ok_i),
  .aux_below_ref_i(aux_below_ref_i), .watchdog_kick_in_i(watchdog_kick_in_i),
  .reset_n_pin_i(reset_n_pin_i), .reset_hi_o(reset_hi_o), .reset_hi_oe_n_o(reset_hi_oe_n_o),
  .reset_lo_o(reset_lo_o), .reset_lo_oe_n_o(reset_lo_oe_n_o), .aux_low_out_o(aux_low_out_o),
  .aux_low_out_oe_n_o(aux_low_out_oe_n_o), .write_inhibit_o(write_inhibit_o));
`default_nettype wire

/* verif/ssw_host.sv */
// Host model: services the watchdog and presses manual reset
`timescale 1ns/1ps
`default_nettype none
module ssw_host (
  // Clock and commands
  input  wire logic clock_i,
  input  wire logic kick_en_i,
  input  wire logic press_i,
  // Reset wire from the device
  input  wire logic dev_lo_i,
  input  wire logic dev_lo_oe_n_i,
  // Host pins
  output logic      kick_o,
  output logic      pin_o
);
  logic [3:0] cnt_ff = 4'h0;
  logic       kick_ff = 1'h0;
  always @(negedge clock_i) begin
    cnt_ff <= cnt_ff + 4'h1;
    if (kick_en_i && dev_lo_oe_n_i && cnt_ff == 4'h0) kick_ff <= !kick_ff;
  end
  assign kick_o = kick_ff;
  assign pin_o = !press_i && (dev_lo_oe_n_i || dev_lo_i);
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int HOLD = 20;
  localparam int WDOG = 50;
  logic clock_i = 0, rst_n_i = 0, supply_ok = 0, aux_below = 0, kick_en = 0, press = 0;
  wire logic kick, pin, hi, hi_oe_n, lo, lo_oe_n, aux_d, aux_oe_n, winh;
  int failures = 0, samples_checked = 0, cycles = 0, n;
  always #10 clock_i = ~clock_i;
  ssw_supervisor #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG)) dut (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .supply_ok_i(supply_ok), .aux_below_ref_i(aux_below),
    .watchdog_kick_in_i(kick), .reset_n_pin_i(pin), .reset_hi_o(hi), .reset_hi_oe_n_o(hi_oe_n),
    .reset_lo_o(lo), .reset_lo_oe_n_o(lo_oe_n), .aux_low_out_o(aux_d),
    .aux_low_out_oe_n_o(aux_oe_n), .write_inhibit_o(winh));
  ssw_host host (.clock_i(clock_i), .kick_en_i(kick_en), .press_i(press), .dev_lo_i(lo),
    .dev_lo_oe_n_i(lo_oe_n), .kick_o(kick), .pin_o(pin));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_out(input logic lvl);
    n = 0;
    while (lo_oe_n !== lvl && n < 200) begin
      @(negedge clock_i);
      n++;
    end
  endtask
  task automatic end_of_test;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic t_power_up;
    repeat (3) @(negedge clock_i);
    check({winh, hi, hi_oe_n, aux_d}, 4'hc);
    supply_ok = 1;
    wait_out(1);
    check(n >= HOLD && n <= HOLD + 5, 1'h1);
    check({hi, hi_oe_n, winh}, 3'h2);
  endtask
  task automatic t_brownout;
    supply_ok = 0;
    @(negedge clock_i);
    supply_ok = 1;
    check(winh, 1'h1);
    @(negedge clock_i);
    check({winh, lo_oe_n, hi, lo}, 4'h2);
    wait_out(1);
    check(n >= HOLD && n <= HOLD + 5, 1'h1);
  endtask
  task automatic t_manual;
    press = 1;
    repeat (2) @(negedge clock_i);
    press = 0;
    check(lo_oe_n, 1'h0);
    wait_out(1);
    check(n >= HOLD && n <= HOLD + 5, 1'h1);
  endtask
  task automatic t_watchdog;
    wait_out(0);
    check(n >= WDOG - 2 && n <= WDOG + 3, 1'h1);
    wait_out(1);
    check(n >= HOLD && n <= HOLD + 5, 1'h1);
  endtask
  task automatic t_kick_aux;
    kick_en = 1;
    aux_below = 1;
    @(negedge clock_i);
    check(aux_oe_n, 1'h0);
    aux_below = 0;
    n = 0;
    repeat (3 * WDOG) begin
      @(negedge clock_i);
      if (lo_oe_n !== 1'b1) n++;
    end
    check(8'(n), 8'h00);
    check({aux_oe_n, lo_oe_n}, 2'h3);
    kick_en = 0;
  endtask
  task automatic t_mid_reset;
    rst_n_i = 0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1;
    @(negedge clock_i);
    check({hi, hi_oe_n, lo_oe_n, winh}, 4'h8);
    wait_out(1);
    check(n >= HOLD && n <= HOLD + 5, 1'h1);
  endtask
  initial begin
    repeat (12) @(negedge clock_i);
    rst_n_i = 1;
    t_power_up();
    t_brownout();
    t_manual();
    t_watchdog();
    t_kick_aux();
    t_mid_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
